// ==== logic/akd_map.svh ====
// Constants for the key derivation engine: widths, field positions, pass start values and round counts.
`ifndef AKD_MAP_SVH
`define AKD_MAP_SVH
`define AKD_BLK_W     128
`define AKD_HALF_W    64
`define AKD_TAG_W     32
`define AKD_TAG_LSB   96
`define AKD_DCK_W     64
`define AKD_LEN_W     8
`define AKD_HLEN_W    7
`define AKD_LAST_RND  4'hA
`define AKD_FIRST_RND 4'h1
`define AKD_RCON_INIT 8'h01
`define AKD_GF_POLY   8'h1B
`define AKD_SBOX_C    8'h63
`endif

// ==== logic/akd_pkg.sv ====
// Types shared by the key derivation engine and its users.
package akd_pkg;
  typedef enum logic {
    AKD_SESSION = 1'b0,
    AKD_TAG     = 1'b1
  } akd_mode_t;

  typedef enum logic [2:0] {
    AKD_ST_IDLE  = 3'b001,
    AKD_ST_PASS1 = 3'b010,
    AKD_ST_PASS2 = 3'b100
  } akd_fsm_t;

  typedef struct packed {
    logic           start;
    akd_mode_t      mode;
    logic [127:0]   secret_input;
    logic [7:0]     secret_len;
    logic [63:0]    first_public_input;
    logic [6:0]     first_len;
    logic [63:0]    second_public_input;
    logic [6:0]     second_len;
    logic [7:0]     cipher_key_len;
  } akd_req_t;

  typedef struct packed {
    logic           busy;
    logic           done;
    logic [127:0]   intermediate;
    logic [31:0]    auth_tag;
    logic [127:0]   result;
  } akd_rsp_t;
endpackage : akd_pkg

// ==== logic/akd_top.sv ====
// Two-pass AES-128 authentication and key derivation engine with the derived-key byte map.
// Notes on behaviour
// - Derived 64-bit key is byte-reversed into the cipher key vector, bit order kept.
// - Secret input up to 128 bits, host supplies its length m.
// - Two public inputs up to 64 bits each, host supplies lengths n and r.
// - Result is 128 bits; tag mode gives 32-bit tag plus t-bit cipher key.
// - Two modes: session key derivation, and tag with cipher key derivation.
// - AES key is secret bits 0..m-1, all later positions zero.
// - Plaintext: first public input padded to 64, second padded from 64 to 127.
// - Both modes first encrypt padded plaintext under padded key giving the intermediate.
// - Session mode encrypts intermediate again under same key; all 128 bits output.
// - Tag mode outputs intermediate bits 0..31 as the authentication tag.
// - Tag mode second encryption uses intermediate with only bit 127 inverted.
// - Tag mode outputs second ciphertext bits 0..t-1 as cipher key.
// - Bit 0 is the most significant bit; unused low bits are zero.
// - First session reference vector gives FAA865E7... and 294016C0... results.
// - Second session reference vector gives 2F2863B4... and 4C3FEA06... results.
// - Derived key holds its most significant byte at bits 63..56.
`timescale 1ns/10ps
`include "akd_map.svh"

module akd_top #(
  // Block, half-block and tag widths, and the rounds in one pass.
  parameter int BLK_W  = `AKD_BLK_W,
  parameter int HALF_W = `AKD_HALF_W,
  parameter int TAG_W  = `AKD_TAG_W,
  parameter int ROUNDS = int'(`AKD_LAST_RND)
) (
  // Clock and reset.
  input  wire logic              clk,
  input  wire logic              reset_n,
  // Request from the host controller.
  input  wire akd_pkg::akd_req_t req,
  // Results to the host controller.
  output akd_pkg::akd_rsp_t      rsp,
  // Derived key and its mapped cipher key vector.
  input  wire logic [63:0]       derived_key_in,
  output logic [63:0]            cipher_key_vector
);
  import akd_pkg::*;

  typedef struct packed {
    akd_fsm_t     fsm;
    akd_mode_t    mode;
    logic [7:0]   tlen;
    logic [127:0] key;
    logic [127:0] rk;
    logic [127:0] blk;
    logic [7:0]   rcon;
    logic [3:0]   rnd;
    akd_rsp_t     rsp;
    logic [63:0]  ckv;
  } akd_state_t;

  akd_state_t state_reg;
  akd_state_t state_next;

  //////////////////////////////////////////////////////////////////////////////////////////////////
  // The round logic and the package types are built for the AES-128 sizes only.

  if (BLK_W != `AKD_BLK_W || HALF_W != `AKD_HALF_W ||
      TAG_W != `AKD_TAG_W || ROUNDS != int'(`AKD_LAST_RND)) begin : g_size_check
    $error("akd_top serves only the AES-128 block, key and tag sizes");
  end

  //////////////////////////////////////////////////////////////////////////////////////////////////
  // GF(2^8) arithmetic and the AES round, with vector bit 127 as sequence index 0.

  function automatic logic [7:0] gmul(input logic [7:0] a, input logic [7:0] b);
    logic [7:0] p;
    logic [7:0] x;
    p = 8'h00;
    x = a;
    for (int i = 0; i < 8; i++) begin
      if (b[i]) begin
        p = p ^ x;
      end
      x = {x[6:0], 1'b0} ^ (x[7] ? `AKD_GF_POLY : 8'h00);
    end
    return p;
  endfunction

  // Substitution built from the field inverse (x^254) and the affine map.
  function automatic logic [7:0] sbox(input logic [7:0] a);
    logic [7:0] p;
    logic [7:0] q;
    p = a;
    q = 8'h01;
    for (int i = 0; i < 7; i++) begin
      p = gmul(p, p);
      q = gmul(q, p);
    end
    return q ^ {q[6:0], q[7]} ^ {q[5:0], q[7:6]} ^ {q[4:0], q[7:5]} ^ {q[3:0], q[7:4]} ^ `AKD_SBOX_C;
  endfunction

  // One key schedule step: rotate, substitute and add the round constant to the last word.
  function automatic logic [127:0] key_step(input logic [127:0] k, input logic [7:0] rc);
    logic [31:0] t;
    logic [127:0] o;
    t = {sbox(k[23:16]) ^ rc, sbox(k[15:8]), sbox(k[7:0]), sbox(k[31:24])};
    o[127:96] = k[127:96] ^ t;
    o[95:64]  = k[95:64] ^ o[127:96];
    o[63:32]  = k[63:32] ^ o[95:64];
    o[31:0]   = k[31:0] ^ o[63:32];
    return o;
  endfunction

  // State bytes run column by column, byte 0 in bits 127 down to 120.
  function automatic logic [127:0] aes_round(input logic [127:0] s, input logic [127:0] k, input logic last);
    logic [7:0] b [16];
    logic [7:0] t [16];
    logic [7:0] m;
    logic [127:0] o;
    for (int i = 0; i < 16; i++) begin
      b[i] = sbox(s[127 - 8 * i -: 8]);
    end
    for (int i = 0; i < 16; i++) begin
      t[i] = b[(i % 4) + 4 * (((i / 4) + (i % 4)) % 4)];
    end
    for (int c = 0; c < 4; c++) begin
      for (int r = 0; r < 4; r++) begin
        m = gmul(t[4 * c + r], 8'h02) ^ gmul(t[4 * c + (r + 1) % 4], 8'h03)
          ^ t[4 * c + (r + 2) % 4] ^ t[4 * c + (r + 3) % 4];
        o[127 - 8 * (4 * c + r) -: 8] = last ? t[4 * c + r] : m;
      end
    end
    return o ^ k;
  endfunction

  //////////////////////////////////////////////////////////////////////////////////////////////////
  // Sequencer: padding, two chained encryptions on one core, result capture.

  logic [127:0] key_mask;
  logic [63:0]  first_mask;
  logic [63:0]  second_mask;
  logic [127:0] tlen_mask;
  logic [127:0] rk_step;
  logic [127:0] blk_step;

  always_comb begin
    // Keep the leading len bits; a length at or above the width keeps all of them.
    key_mask    = ~({BLK_W{1'b1}} >> req.secret_len);
    first_mask  = ~({HALF_W{1'b1}} >> req.first_len);
    second_mask = ~({HALF_W{1'b1}} >> req.second_len);
    tlen_mask   = ~({BLK_W{1'b1}} >> state_reg.tlen);
    rk_step     = key_step(state_reg.rk, state_reg.rcon);
    blk_step    = aes_round(state_reg.blk, rk_step, state_reg.rnd == `AKD_LAST_RND);
  end

  always_comb begin
    state_next = state_reg;
    // Most significant derived byte lands in the low byte of the vector.
    for (int i = 0; i < 8; i++) begin
      state_next.ckv[8 * i +: 8] = derived_key_in[63 - 8 * i -: 8];
    end
    // The key vector copy above runs on every edge, whatever the sequencer is doing.
    unique case (state_reg.fsm)
      AKD_ST_IDLE: begin
        if (req.start) begin
          // Inputs are sampled on this edge only; the host may change them afterwards.
          state_next.mode     = req.mode;
          state_next.tlen     = req.cipher_key_len;
          state_next.key      = req.secret_input & key_mask;
          state_next.rk       = req.secret_input & key_mask;
          state_next.blk      = {req.first_public_input & first_mask,
                                 req.second_public_input & second_mask} ^ (req.secret_input & key_mask);
          state_next.rcon     = `AKD_RCON_INIT;
          state_next.rnd      = `AKD_FIRST_RND;
          state_next.rsp.done = 1'b0;
          state_next.rsp.busy = 1'b1;
          state_next.fsm      = AKD_ST_PASS1;
        end
      end
      AKD_ST_PASS1, AKD_ST_PASS2: begin
        // Starts arriving here are dropped.                          
        state_next.rk   = rk_step;
        state_next.blk  = blk_step;
        state_next.rcon = gmul(state_reg.rcon, 8'h02);
        state_next.rnd  = state_reg.rnd + 4'h1;
        if (state_reg.rnd == `AKD_LAST_RND) begin
          // Last round: reload the original key so the next pass starts from round one.
          state_next.rk   = state_reg.key;
          state_next.rcon = `AKD_RCON_INIT;
          state_next.rnd  = `AKD_FIRST_RND;
          if (state_reg.fsm == AKD_ST_PASS1) begin
            state_next.rsp.intermediate = blk_step;
            state_next.rsp.auth_tag     = (state_reg.mode == AKD_TAG) ?
                                          blk_step[BLK_W - 1 -: TAG_W] : 32'h0000_0000;
            state_next.blk = (state_reg.mode == AKD_TAG) ?
                             {blk_step[127:1], ~blk_step[0]} ^ state_reg.key :
                             blk_step ^ state_reg.key;
            state_next.fsm = AKD_ST_PASS2;
          end else begin
            state_next.rsp.result = (state_reg.mode == AKD_TAG) ?
                                    blk_step & tlen_mask : blk_step;
            state_next.rsp.done   = 1'b1;
            state_next.rsp.busy   = 1'b0;
            state_next.fsm        = AKD_ST_IDLE;
          end
        end
      end
      default: begin
        // A corrupt state code returns the engine to idle.
        state_next.fsm = AKD_ST_IDLE;
      end
    endcase
  end

  // Asynchronous clear leaves the engine idle with every result field at zero.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= '{fsm: AKD_ST_IDLE, mode: AKD_SESSION, default: '0};
    end else begin
      state_reg <= state_next;
    end
  end

  // Ports are plain copies of registered state, so no logic sits between flops and pins.
  assign rsp               = state_reg.rsp;
  assign cipher_key_vector = state_reg.ckv;

endmodule // akd_top

// ==== tb/akd_checker.sv ====
// Port assertions for the key derivation engine.
`timescale 1ns/10ps
module akd_checker (
  // Clock and reset.
  input wire logic              clk,
  input wire logic              reset_n,
  // Engine ports.
  input wire akd_pkg::akd_req_t req,
  input wire akd_pkg::akd_rsp_t rsp,
  input wire logic [63:0]       derived_key_in,
  input wire logic [63:0]       cipher_key_vector
);
  import akd_pkg::*;
  logic up_reg;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) up_reg <= 1'b0;
    else up_reg <= 1'b1;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence s_taken;
    req.start && !rsp.busy;
  endsequence
  sequence s_run;
    ##1 rsp.busy ##19 (rsp.busy && !rsp.done) ##1 (rsp.done && !rsp.busy);
  endsequence
  a_map_bytes: assert property (up_reg |-> cipher_key_vector ==
    {$past(derived_key_in[7:0]), $past(derived_key_in[15:8]), $past(derived_key_in[23:16]),
     $past(derived_key_in[31:24]), $past(derived_key_in[39:32]), $past(derived_key_in[47:40]),
     $past(derived_key_in[55:48]), $past(derived_key_in[63:56])})
    else $error("key vector not byte reversed");
  a_run_timing: assert property (s_taken |-> s_run)
    else $error("run length wrong");
  a_start_clears: assert property (s_taken |=> !rsp.done)
    else $error("done kept after start");
  a_done_hold: assert property (rsp.done && !req.start |=> rsp.done && $stable(rsp.result))
    else $error("result not held");
  a_mid_stable: assert property (s_taken |-> ##12 ($stable(rsp.intermediate) [*8]))
    else $error("intermediate moved");
  a_tag_field: assert property (s_taken and req.mode == AKD_TAG |-> ##21 rsp.auth_tag == rsp.intermediate[127:96])
    else $error("tag bits wrong");
  a_session_tag: assert property (s_taken and req.mode == AKD_SESSION |-> ##21 rsp.auth_tag == 32'h0)
    else $error("tag in session mode");
  a_key_trunc: assert property (s_taken and req.mode == AKD_TAG && req.cipher_key_len == 8'h00 |-> ##21 rsp.result == '0)
    else $error("short key not cleared");
  a_reset_idle: assert property ($rose(reset_n) |-> !rsp.busy && !rsp.done)
    else $error("not idle after reset");
endmodule // akd_checker
bind akd_top akd_checker i_chk (.clk(clk), .reset_n(reset_n), .req(req), .rsp(rsp),
  .derived_key_in(derived_key_in), .cipher_key_vector(cipher_key_vector));

// ==== tb/akd_host_model.sv ====
// Host controller model presenting a request with a one-cycle start.
`timescale 1ns/10ps
module akd_host_model (
  // Clock and reset.
  input  wire logic              clk,
  input  wire logic              reset_n,
  // Bench command.
  input  wire logic              go,
  input  wire akd_pkg::akd_req_t cmd,
  // Engine side.
  output akd_pkg::akd_req_t      req
);
  import akd_pkg::*;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      req <= '0;
    end else begin
      req <= {go, cmd[$bits(akd_req_t) - 2:0]};
    end
  end
endmodule // akd_host_model

// ==== tb/akd_top_bench.sv ====
// Self-checking bench for the key derivation engine.
`timescale 1ns/10ps
module akd_top_bench;
  import akd_pkg::*;
  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        go = 1'b0;
  logic [63:0] dk = '0;
  logic [63:0] v;
  logic [63:0] ckv;
  logic [63:0] exp_q[$];
  logic [127:0] rnd;
  akd_req_t    cmd = '0;
  akd_req_t    req;
  akd_rsp_t    rsp;
  int          error_cnt = 0;
  int          cmp_count = 0;
  always #25 clk = ~clk;
  akd_host_model i_host (.clk(clk), .reset_n(reset_n), .go(go), .cmd(cmd), .req(req));
  akd_top i_dut (.clk(clk), .reset_n(reset_n), .req(req), .rsp(rsp), .derived_key_in(dk), .cipher_key_vector(ckv));
  task automatic check(input logic [127:0] seen, input logic [127:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("compares=%0d errors=%0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  function automatic logic [63:0] rev_bytes(input logic [63:0] x);
    logic [63:0] r;
    for (int i = 0; i < 8; i++) r[8*i +: 8] = x[56-8*i +: 8];
    return r;
  endfunction
  // Reference model: byte-wise AES-128 and the padding, written from the rules.
  function automatic logic [7:0] m_mul(input logic [7:0] a, input logic [7:0] b);
    logic [7:0] p;
    p = 8'h00;
    for (int i = 0; i < 8; i++) begin
      if (b[i]) p = p ^ a;
      a = (a << 1) ^ (a[7] ? 8'h1B : 8'h00);
    end
    return p;
  endfunction
  function automatic logic [7:0] m_sub(input logic [7:0] a);
    logic [7:0] v;
    logic [7:0] c;
    logic [7:0] o;
    v = 8'h00;
    c = 8'h63;
    for (int j = 1; j < 256; j++) begin
      if (m_mul(a, j[7:0]) == 8'h01) v = j[7:0];
    end
    for (int i = 0; i < 8; i++) o[i] = v[i] ^ v[(i + 4) % 8] ^ v[(i + 5) % 8] ^ v[(i + 6) % 8] ^ v[(i + 7) % 8] ^ c[i];
    return o;
  endfunction
  function automatic logic [127:0] m_aes(input logic [127:0] key, input logic [127:0] pt);
    logic [7:0] s [16];
    logic [7:0] k [16];
    logic [7:0] t [16];
    logic [7:0] rc;
    logic [127:0] o;
    rc = 8'h01;
    for (int i = 0; i < 16; i++) begin
      k[i] = key[127 - 8 * i -: 8];
      s[i] = pt[127 - 8 * i -: 8] ^ k[i];
    end
    for (int rd = 1; rd <= 10; rd++) begin
      k[0] = k[0] ^ m_sub(k[13]) ^ rc;
      k[1] = k[1] ^ m_sub(k[14]);
      k[2] = k[2] ^ m_sub(k[15]);
      k[3] = k[3] ^ m_sub(k[12]);
      for (int i = 4; i < 16; i++) k[i] = k[i] ^ k[i - 4];
      rc = m_mul(rc, 8'h02);
      for (int i = 0; i < 16; i++) t[i] = m_sub(s[4 * (((i / 4) + (i % 4)) % 4) + i % 4]);
      for (int i = 0; i < 16; i++) begin
        s[i] = t[i];
        if (rd < 10) s[i] = m_mul(t[i], 8'h02) ^ m_mul(t[i / 4 * 4 + (i + 1) % 4], 8'h03)
                            ^ t[i / 4 * 4 + (i + 2) % 4] ^ t[i / 4 * 4 + (i + 3) % 4];
        s[i] = s[i] ^ k[i];
      end
    end
    for (int i = 0; i < 16; i++) o[127 - 8 * i -: 8] = s[i];
    return o;
  endfunction
  function automatic logic [127:0] m_keep(input logic [127:0] x, input int len);
    for (int i = 0; i < 128; i++) begin
      if (i >= len) x[127 - i] = 1'b0;
    end
    return x;
  endfunction
  task automatic setup(input akd_mode_t md, input logic [127:0] s, input logic [7:0] m, input logic [63:0] a,
                       input logic [6:0] n, input logic [63:0] b, input logic [6:0] r, input logic [7:0] t);
    cmd <= {1'b0, md, s, m, a, n, b, r, t};
  endtask
  // A poke pulses start again mid-run with a different secret; it must be ignored.
  task automatic run(input logic poke, input logic lit, input logic [127:0] ew, input logic [127:0] ek);
    logic [127:0] mk;
    logic [127:0] mp;
    logic [127:0] mw;
    logic [127:0] me;
    @(posedge clk);
    mk = m_keep(cmd.secret_input, cmd.secret_len);
    mp = m_keep({cmd.first_public_input, 64'h0}, cmd.first_len)
       | (m_keep({cmd.second_public_input, 64'h0}, cmd.second_len) >> 64);
    mw = m_aes(mk, mp);
    me = (cmd.mode == AKD_TAG) ? m_keep(m_aes(mk, mw ^ 128'h1), cmd.cipher_key_len) : m_aes(mk, mw);
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (3) @(posedge clk);
    if (poke) begin
      go <= 1'b1;
      cmd.secret_input <= ~cmd.secret_input;
      @(posedge clk);
      go <= 1'b0;
    end
    for (int i = 0; i < 40 && rsp.done !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    if (rsp.done === 1'b1) begin
      check(rsp.intermediate, mw);
      check(rsp.result, me);
      check(rsp.auth_tag, cmd.mode == AKD_TAG ? mw[127:96] : 32'h0);
      check(rsp.busy, 1'b0);
      if (lit) begin
        check(rsp.intermediate, ew);
        check(rsp.result, ek);
      end
    end else begin
      error_cnt++;
      report_and_stop();
    end
  endtask
  initial begin
    void'($urandom(32'h39C3AF39));
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    for (int i = 0; i < 21; i++) begin
      @(posedge clk);
      v = (i == 0) ? 64'h8560DC324EA49F37 : {$urandom, $urandom};
      dk <= v;
      #1;
      if (i > 0) check(ckv, exp_q.pop_front());
      exp_q.push_back(rev_bytes(v));
    end
    setup(AKD_SESSION, 128'h42025EE339743AF647B5778025E9B66D, 8'h80, 64'hA0F3624E949640A0, 7'h40,
          64'h17DA4751F5B2B180, 7'h40, 8'h80);
    run(1'b0, 1'b1, 128'hFAA865E7D215652B07C045C8EA8F3327, 128'h294016C034CD1A5576081826366A7E4A);
    setup(AKD_SESSION, 128'h5DDB5285D9072931833B35567776898A, 8'h80, 64'h8493A3292770FA99, 7'h40,
          64'hB950D6D2E77E641D, 7'h40, 8'h80);
    run(1'b1, 1'b1, 128'h2F2863B43F6718197E292FCF6BFAD22C, 128'h4C3FEA069EBF6CFE419B045447FCFE34);
    setup(AKD_TAG, 128'h42025EE339743AF647B5778025E9B66D, 8'h80, 64'hA0F3624E949640A0, 7'h40,
          64'h17DA4751F5B2B180, 7'h40, 8'h00);
    run(1'b0, 1'b1, 128'hFAA865E7D215652B07C045C8EA8F3327, '0);
    rnd = {$urandom, $urandom, $urandom, $urandom};
    setup(AKD_SESSION, {80'hD080644999A0D8B73653, rnd[47:0]}, 8'h50, {48'h89E394B277B6, rnd[63:48]}, 7'h30,
          {60'hD48E6D18F1C655E, rnd[67:64]}, 7'h3C, 8'h80);
    run(1'b0, 1'b1, 128'h1A11459082980B50D212D04B728B2D5E, 128'h9F05E22ADBCF67D829DB6B1810B4BA50);
    // Random legal lengths; tag mode reaches the inverted-bit second pass and the key cut.
    for (int j = 0; j < 4; j++) begin
      rnd = {$urandom, $urandom, $urandom, $urandom};
      setup(j < 3 ? AKD_TAG : AKD_SESSION, rnd, 8'($urandom_range(128)), {$urandom, $urandom},
            7'($urandom_range(64)), {$urandom, $urandom}, 7'($urandom_range(64)),
            j == 0 ? 8'h80 : 8'($urandom_range(128)));
      run(1'b0, 1'b0, '0, '0);
    end
    report_and_stop();
  end
endmodule // akd_top_bench
